// [fss_pkg.sv]
// Constants and types shared by the flash self-program sequencer
package fss_pkg;

  localparam logic [2:0] OFF_CTRL  = 3'h0;
  localparam logic [2:0] OFF_KEY   = 3'h1;
  localparam logic [2:0] OFF_ADRL  = 3'h2;
  localparam logic [2:0] OFF_ADRH  = 3'h3;
  localparam logic [2:0] OFF_DATL  = 3'h4;
  localparam logic [2:0] OFF_DATH  = 3'h5;

  localparam int CB_READ   = 0;
  localparam int CB_LAUNCH = 1;
  localparam int CB_PERMIT = 2;
  localparam int CB_FREE   = 4;
  localparam int CB_LATCH  = 5;
  localparam int CB_CFG    = 6;
  localparam int CB_PGD    = 7;

  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  ADRH_RDMASK = 8'h80;
  localparam logic [7:0]  KEY_FIRST   = 8'h55;
  localparam logic [7:0]  KEY_SECOND  = 8'haa;
  localparam logic [13:0] LATCH_RESET = 14'h3fff;
  localparam int          N_LATCH     = 8;
  localparam int          LATCH_AW    = 3;

  localparam logic [14:0] CFG_USER_LAST = 15'h0003;
  localparam logic [14:0] CFG_DEVID     = 15'h0006;
  localparam logic [14:0] CFG_WORD1     = 15'h0007;
  localparam logic [14:0] CFG_WORD2     = 15'h0008;
  localparam logic [2:0]  CFG_WR_LATCHES = 3'h3;

  localparam int CLK_MHZ       = 250;
  localparam int ERASE_TIME_US = 2000;
  localparam int ERASE_CYC     = ERASE_TIME_US * CLK_MHZ;
  localparam int PREP_CYC      = 2;
  localparam int CNT_W         = 20;

  typedef enum logic [2:0] {
    FSS_IDLE, FSS_PREP, FSS_ERASE, FSS_PROG, FSS_RDREQ, FSS_RDCAP
  } fss_state_t;

  typedef struct packed {
    logic        erase;
    logic        prog;
    logic        rd;
    logic [15:0] addr;
    logic [13:0] wdata;
  } fss_flash_req_t;

endpackage

// [fss_unlock.sv]
// Two-byte unlock key tracker
`timescale 1ns/1ps
`default_nettype none
module fss_unlock
  import fss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       consume,
  output logic            armed
);

  logic [1:0] step_reg;
  logic [1:0] step_next;

  always_comb begin
    step_next = step_reg;
    if (key_wr) begin
      if (key_data == KEY_FIRST) begin
        step_next = 2'h1;
      end else if (key_data == KEY_SECOND && step_reg == 2'h1) begin
        step_next = 2'h2;
      end else begin
        step_next = 2'h0;
      end
    end else if (consume) begin
      step_next = 2'h0; // Key is single use
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step_reg <= 2'h0;
    end else begin
      step_reg <= step_next;
    end
  end

  assign armed = (step_reg == 2'h2);

endmodule // fss_unlock
`default_nettype wire

// [fss_sequencer.sv]
// Flash self-program sequencer: registers, latches, erase and program
// How it works
// - Erase works on whole rows only
// - Row-erase bit reads set until erase ends
// - Core stalls for erase time after prep
// - Program start never triggers an erase
// - At most eight aligned words per program
// - Latches reset to 3fff after programming
// - Latch-only mode loads latch, no programming
// - Otherwise load final latch, program block
// - Whole block programmed (latches 0-3 only in config space), unloaded latches kept
// - Load or program needs the unlock keys
// - Config select targets ID and config region
// - User IDs writable, ID/config words read-only
// - Bad config-space read clears data pair
// - Data pair holds a 14-bit word
// - Address pair holds a 15-bit address
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fss_sequencer
  import fss_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic [13:0] flash_rdata,
  output fss_flash_req_t  flash_req,
  output logic            cpu_stall,
  output logic            busy
);

  fss_state_t     state_reg, state_next;
  logic [7:0]     ctrl_reg, ctrl_next;
  logic [14:0]    adr_reg, adr_next;
  logic [13:0]    dat_reg, dat_next;
  logic [13:0]    latch_reg [N_LATCH];
  logic [13:0]    latch_next [N_LATCH];
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [LATCH_AW-1:0] idx_reg, idx_next;
  fss_flash_req_t req_reg, req_next;
  logic [7:0]     rdata_reg, rdata_next;
  logic           stall_reg, stall_next;

  logic           armed;
  logic           ctrl_wr;
  logic           key_wr;
  logic           launch;
  logic           go;
  logic           cfg_rd_ok;
  logic           cfg_wr_ok;
  logic           cfg_sel;
  logic [CNT_W-1:0] erase_last;
  logic [CNT_W-1:0] prep_last;

  assign ctrl_wr    = reg_wr && reg_addr == OFF_CTRL;
  assign key_wr     = reg_wr && reg_addr == OFF_KEY;
  assign erase_last = CNT_W'(ERASE_CYCLES - 1);
  assign prep_last  = CNT_W'(PREP_CYC - 1);
  // Launch is honoured only with permit written alongside it
  assign launch = ctrl_wr && state_reg == FSS_IDLE
                  && reg_wdata[CB_LAUNCH] && reg_wdata[CB_PERMIT];
  assign go      = launch && armed && reg_wdata[CB_PGD];
  assign cfg_sel = reg_wdata[CB_CFG];
  assign cfg_rd_ok = adr_reg <= CFG_USER_LAST || adr_reg == CFG_DEVID
                     || adr_reg == CFG_WORD1 || adr_reg == CFG_WORD2;
  assign cfg_wr_ok = adr_reg <= CFG_USER_LAST;

  fss_unlock u_unlock (
    .clk      (clk),
    .rst_b    (rst_b),
    .key_wr   (key_wr),
    .key_data (reg_wdata),
    .consume  (ctrl_wr),
    .armed    (armed)
  );

  always_comb begin
    state_next = state_reg;
    ctrl_next  = ctrl_reg;
    adr_next   = adr_reg;
    dat_next   = dat_reg;
    cnt_next   = cnt_reg;
    idx_next   = idx_reg;
    req_next   = '0;
    for (int i = 0; i < N_LATCH; i++) begin
      latch_next[i] = latch_reg[i];
    end
    // Software writes to address and data; busy blocks nothing here
    if (reg_wr && reg_addr == OFF_ADRL) begin
      adr_next[7:0] = reg_wdata;
    end
    if (reg_wr && reg_addr == OFF_ADRH) begin
      adr_next[14:8] = reg_wdata[6:0];
    end
    if (reg_wr && reg_addr == OFF_DATL) begin
      dat_next[7:0] = reg_wdata;
    end
    if (reg_wr && reg_addr == OFF_DATH) begin
      dat_next[13:8] = reg_wdata[5:0];
    end
    unique case (state_reg)
      FSS_IDLE: begin
        if (ctrl_wr) begin
          ctrl_next = reg_wdata;
          ctrl_next[CB_LAUNCH] = 1'b0;
          ctrl_next[CB_READ]   = 1'b0;
          if (reg_wdata[CB_READ]) begin
            ctrl_next[CB_READ] = 1'b1;
            req_next.rd   = 1'b1;
            req_next.addr = {cfg_sel, adr_reg};
            state_next    = FSS_RDREQ;
          end else if (go && reg_wdata[CB_FREE] && !cfg_sel) begin
            // Row erase; flash clears the row holding the address
            ctrl_next[CB_LAUNCH] = 1'b1;
            cnt_next   = '0;
            state_next = FSS_PREP;
          end else if (go && !reg_wdata[CB_FREE]
                       && (!cfg_sel || cfg_wr_ok)) begin
            latch_next[adr_reg[LATCH_AW-1:0]] = dat_reg;
            if (!reg_wdata[CB_LATCH]) begin
              ctrl_next[CB_LAUNCH] = 1'b1;
              idx_next   = '0;
              state_next = FSS_PROG;
            end
            // Latch-only mode stops after the load
          end
        end
      end
      FSS_PREP: begin
        // Two core cycles pass before the stall begins
        if (cnt_reg == prep_last) begin
          cnt_next       = '0;
          req_next.erase = 1'b1;
          req_next.addr  = {1'b0, adr_reg};
          state_next     = FSS_ERASE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      FSS_ERASE: begin
        if (cnt_reg == erase_last) begin
          ctrl_next[CB_LAUNCH] = 1'b0;
          ctrl_next[CB_FREE]   = 1'b0;
          state_next = FSS_IDLE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      FSS_PROG: begin
        // Every latch of the block goes out, loaded or not; in config space only latches 0-3 get a program pulse
        req_next.prog  = !ctrl_reg[CB_CFG] || idx_reg <= CFG_WR_LATCHES;
        req_next.addr  = {ctrl_reg[CB_CFG],
                          adr_reg[14:LATCH_AW], idx_reg};
        req_next.wdata = latch_reg[idx_reg];
        idx_next = idx_reg + 1'b1;
        if (idx_reg == LATCH_AW'(N_LATCH - 1)) begin
          for (int i = 0; i < N_LATCH; i++) begin
            latch_next[i] = LATCH_RESET;
          end
          ctrl_next[CB_LAUNCH] = 1'b0;
          state_next = FSS_IDLE;
        end
      end
      FSS_RDREQ: begin
        state_next = FSS_RDCAP;
      end
      FSS_RDCAP: begin
        // Read data arrives the cycle after the request is seen
        if (ctrl_reg[CB_CFG] && !cfg_rd_ok) begin
          dat_next = '0;
        end else begin
          dat_next = flash_rdata;
        end
        ctrl_next[CB_READ] = 1'b0;
        state_next = FSS_IDLE;
      end
    endcase
  end

  always_comb begin
    stall_next = (state_next == FSS_ERASE);
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_CTRL: rdata_next = ctrl_reg;
        OFF_ADRL: rdata_next = adr_reg[7:0];
        OFF_ADRH: rdata_next = ADRH_RDMASK | {1'b0, adr_reg[14:8]};
        OFF_DATL: rdata_next = dat_reg[7:0];
        OFF_DATH: rdata_next = {2'b00, dat_reg[13:8]};
        default:  rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= FSS_IDLE;
      ctrl_reg  <= CTRL_RESET;
      adr_reg   <= '0;
      dat_reg   <= '0;
      cnt_reg   <= '0;
      idx_reg   <= '0;
      req_reg   <= '0;
      rdata_reg <= 8'h00;
      stall_reg <= 1'b0;
      for (int i = 0; i < N_LATCH; i++) begin
        latch_reg[i] <= LATCH_RESET;
      end
    end else begin
      state_reg <= state_next;
      ctrl_reg  <= ctrl_next;
      adr_reg   <= adr_next;
      dat_reg   <= dat_next;
      cnt_reg   <= cnt_next;
      idx_reg   <= idx_next;
      req_reg   <= req_next;
      rdata_reg <= rdata_next;
      stall_reg <= stall_next;
      for (int i = 0; i < N_LATCH; i++) begin
        latch_reg[i] <= latch_next[i];
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign flash_req = req_reg;
  assign cpu_stall = stall_reg;
  assign busy      = state_reg != FSS_IDLE;

  // Helper: cycles of the current stall so far, zero again from the second cycle after a stall ends
  logic [CNT_W-1:0] stall_len;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stall_len <= '0;
    end else if (stall_reg) begin
      stall_len <= stall_len + 1'b1;
    end else begin
      stall_len <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_locked_launch: assert property (
    (launch && !armed && !reg_wdata[CB_READ])
      |=> state_reg == FSS_IDLE && !ctrl_reg[CB_LAUNCH])
    else $error("launch without unlock was acted on");
  a_erase_prep: assert property (
    (state_reg == FSS_PREP && $past(state_reg) == FSS_IDLE)
      |-> !cpu_stall ##1 !cpu_stall ##1 (cpu_stall && flash_req.erase))
    else $error("erase stall did not start after two cycles");
  a_stall_length: assert property (
    $fell(cpu_stall) |-> $past(stall_len) == CNT_W'(ERASE_CYCLES - 1))
    else $error("erase stall length wrong");
  a_free_polls: assert property (
    cpu_stall |-> ctrl_reg[CB_FREE] && ctrl_reg[CB_LAUNCH])
    else $error("row erase bit cleared during erase");
  a_prog_block: assert property (
    $rose(state_reg == FSS_PROG)
      |-> (state_reg == FSS_PROG)[*8] ##1 state_reg == FSS_IDLE)
    else $error("program block not eight words");
  a_latch_reset: assert property (
    (state_reg == FSS_PROG && idx_reg == 3'h7)
      |=> latch_reg[0] == LATCH_RESET && latch_reg[7] == LATCH_RESET)
    else $error("latches not reset after program");
  a_latch_only: assert property (
    (go && reg_wdata[CB_LATCH] && !reg_wdata[CB_FREE] && !reg_wdata[CB_READ])
      |=> state_reg == FSS_IDLE ##1 !flash_req.prog)
    else $error("latch-only launch started programming");
  a_no_auto_erase: assert property (
    flash_req.prog |-> !flash_req.erase && !cpu_stall)
    else $error("programming caused an erase");
  a_launch_clear: assert property (
    $fell(busy) |-> !ctrl_reg[CB_LAUNCH] && !ctrl_reg[CB_READ])
    else $error("launch bit not cleared at end");
  a_cfg_clear: assert property (
    (state_reg == FSS_RDCAP && ctrl_reg[CB_CFG] && !cfg_rd_ok)
      |=> dat_reg == 14'h0000)
    else $error("bad config read left data");

endmodule // fss_sequencer
`default_nettype wire

// [fss_flash_model.sv]
// Behavioural flash array that answers sequencer reads
`timescale 1ns/1ps
`default_nettype none
module fss_flash_model
  import fss_pkg::*;
(
  input  wire logic           clk,
  input  wire fss_flash_req_t flash_req,
  output logic [13:0]         flash_rdata
);
  // Stored word is a pattern of its address
  // Outside the answer cycle the bus toggles, so stale data never matches
  always @(posedge clk) begin
    if (flash_req.rd === 1'b1)
      flash_rdata <= flash_req.addr[13:0] ^ 14'h1555;
    else
      flash_rdata <= ~flash_rdata;
  end
endmodule // fss_flash_model
`default_nettype wire

// [tb_fss_sequencer.sv]
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_fss_sequencer
  import fss_pkg::*;
;
  localparam int EC = 20;
  logic           clk = 1'b0;
  logic           rst_b = 1'b0;
  logic [2:0]     reg_addr = 3'h0;
  logic [7:0]     reg_wdata = 8'h00;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  logic [7:0]     reg_rdata;
  logic [13:0]    flash_rdata;
  fss_flash_req_t flash_req;
  logic           cpu_stall;
  logic           busy;
  int             fail_count = 0;
  int             checks_done = 0;
  int             stall_n = 0;
  int             erase_n = 0;
  int             cyc = 0;
  logic [29:0]    progq[$];
  logic [13:0]    lat[8];
  logic [13:0]    e;
  logic [15:0]    erase_at = 16'h0000;

  fss_sequencer #(.ERASE_CYCLES(EC)) fss_sequencer_i (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_rdata(flash_rdata), .flash_req(flash_req),
    .cpu_stall(cpu_stall), .busy(busy));
  fss_flash_model fss_flash_model_i (
    .clk(clk), .flash_req(flash_req), .flash_rdata(flash_rdata));

  always #2 clk = ~clk;

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Monitor of flash traffic; also cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cpu_stall === 1'b1)
      stall_n <= stall_n + 1;
    if (flash_req.erase === 1'b1) begin
      erase_n <= erase_n + 1;
      erase_at <= flash_req.addr;
    end
    if (flash_req.prog === 1'b1)
      progq.push_back({flash_req.addr, flash_req.wdata});
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: register %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [29:0] got, input logic [29:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(reg_rdata, exp);
  endtask

  task automatic unlock(input logic [7:0] k1, input logic [7:0] k2);
    wr(OFF_KEY, k1);
    wr(OFF_KEY, k2);
  endtask

  task automatic setadr(input logic [14:0] a);
    wr(OFF_ADRH, {1'b0, a[14:8]});
    wr(OFF_ADRL, a[7:0]);
  endtask

  // Bounded wait; gives up after 2000 cycles, so a stuck busy shows up in the checks that follow
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // Last program pulse is seen one edge after busy drops
    @(posedge clk);
    #1;
  endtask

  // Loads latches picked by mask, then commits with the last one
  task automatic block(input logic [14:0] base, input logic [7:0] mask);
    logic [13:0] d;
    int i;
    for (i = 0; i < 8; i++) begin
      if (mask[i] || i == 7) begin
        d = 14'($urandom);
        setadr(base + 15'(i));
        wr(OFF_DATL, d[7:0]);
        wr(OFF_DATH, {2'b00, d[13:8]});
        wr(OFF_CTRL, (i == 7) ? 8'h84 : 8'ha4);
        unlock(KEY_FIRST, KEY_SECOND);
        wr(OFF_CTRL, (i == 7) ? 8'h86 : 8'ha6);
        lat[i] = d;
      end
    end
    wait_idle();
    chk_word(30'(progq.size()), 30'd8);
    for (i = 0; i < 8; i++) begin
      chk_word(progq.pop_front(), {1'b0, base[14:3], 3'(i), lat[i]});
      lat[i] = LATCH_RESET;
    end
  endtask

  initial begin
    void'($urandom(36368));
    for (int i = 0; i < 8; i++)
      lat[i] = LATCH_RESET;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFF_CTRL, CTRL_RESET);
    rd(OFF_ADRH, ADRH_RDMASK);
    rd(3'h6, 8'h00);
    wr(OFF_ADRH, 8'h7f);
    rd(OFF_ADRH, 8'hff);
    wr(OFF_DATH, 8'hff);
    rd(OFF_DATH, 8'h3f);
    $display("Register test done");
    // Refused launches first: stray key write after the pair, no permit, spent keys
    setadr(15'h0240);
    // Copy of the row's first word before the row is rewritten
    wr(OFF_CTRL, 8'h81);
    wait_idle();
    e = 14'h0240 ^ 14'h1555;
    rd(OFF_DATL, e[7:0]);
    rd(OFF_DATH, {2'b00, e[13:8]});
    unlock(KEY_FIRST, KEY_SECOND);
    wr(OFF_KEY, 8'h00);
    wr(OFF_CTRL, 8'h96);
    unlock(KEY_FIRST, KEY_SECOND);
    wr(OFF_CTRL, 8'h92);
    wr(OFF_CTRL, 8'h96);
    wr(OFF_CTRL, 8'h94);
    unlock(KEY_FIRST, KEY_SECOND);
    wr(OFF_CTRL, 8'h96);
    rd(OFF_CTRL, 8'h96);
    chk_word(30'(busy), 30'd1);
    wait_idle();
    chk_word(30'(stall_n), 30'(EC));
    chk_word(30'(erase_n), 30'd1);
    chk_word(30'(erase_at), 30'h0240);
    rd(OFF_CTRL, 8'h84);
    $display("Erase test done");
    block(15'h0240, 8'h77);
    block(15'h0120, 8'h00);
    chk_word(30'(erase_n), 30'd1);
    $display("Block write test done");
    // Identity word readable, a hole in the region reads as zero
    for (int k = 0; k < 2; k++) begin
      setadr((k == 0) ? 15'h0006 : 15'h0005);
      wr(OFF_CTRL, 8'hc1);
      wait_idle();
      e = (k == 0) ? (14'h0006 ^ 14'h1555) : 14'h0000;
      rd(OFF_DATL, e[7:0]);
      rd(OFF_DATH, {2'b00, e[13:8]});
    end
    $display("Config read test done");
    give_verdict();
  end
endmodule // tb_fss_sequencer
`default_nettype wire
